// ==== dv/card_config_registers_tb.sv ====
// self-checking bench for the card configuration registers
`timescale 1ns/10ps
module card_config_registers_tb;
  logic core_clk;
  logic rst;
  card_cfg_pkg::host_bus_t host_bus;
  logic [7:0] data_out;
  logic data_oe, status_change_n, ireq_n_out, ireq_oe, wait_n;
  logic ready_busy_state, irq_request, irq_disable_bit;
  logic core_held_in_reset, sleep_request, eight_bit_io_only, ide_mode;
  logic [3:0] irq_line;
  logic taskfile_hit, taskfile_write;
  logic [3:0] taskfile_offset;
  int bad_count, n_tests, cycles, cnt;
  logic [10:0] a0 [4];
  logic [10:0] a1 [4];
  logic h1 [4];
  logic [3:0] o0 [4];
  logic [3:0] o1 [4];
  logic [7:0] opt;

  card_config_registers DUT (.core_clk(core_clk), .rst(rst), .host_bus(host_bus), .data_out(data_out),
    .data_oe(data_oe), .status_change_n(status_change_n), .ireq_n_out(ireq_n_out), .ireq_oe(ireq_oe),
    .wait_n(wait_n), .ready_busy_state(ready_busy_state), .irq_request(irq_request),
    .irq_disable_bit(irq_disable_bit), .core_held_in_reset(core_held_in_reset),
    .sleep_request(sleep_request), .eight_bit_io_only(eight_bit_io_only), .ide_mode(ide_mode),
    .irq_line(irq_line), .taskfile_hit(taskfile_hit), .taskfile_write(taskfile_write),
    .taskfile_offset(taskfile_offset));

  host_socket_model host (.core_clk(core_clk), .wait_n(wait_n), .host_bus(host_bus));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic reset_card(input logic ide);
    host.ide_strap = ide;
    @(posedge core_clk);
    rst <= 1'b1;
    host.idle();
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  // watcher: compare each answer with the oldest note
  always @(negedge core_clk)
  begin
    if (data_oe === 1'b1)
    begin
      if (host.rd_q.size() == 0)
        check({7'h00, data_oe}, 8'h00);
      else
        check(data_out, host.rd_q.pop_front());
    end
    if (taskfile_hit === 1'b1)
    begin
      if (host.tf_q.size() == 0)
        check({7'h00, taskfile_hit}, 8'h00);
      else
        check({3'h0, taskfile_write, taskfile_offset}, {3'h0, host.tf_q.pop_front()});
    end
  end

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      results();
    end
  end

  initial
  begin
    rst = 1'b1;
    ready_busy_state = 1'b1;
    irq_request = 1'b0;
    irq_disable_bit = 1'b0;
    bad_count = 0;
    n_tests = 0;
    cycles = 0;
    void'($urandom(25138));
    a0 = '{11'h005, {7'($urandom), 4'h3}, 11'h1f2, 11'h172};
    a1 = '{11'h401, {7'($urandom), 4'hd}, 11'h175, 11'h1f5};
    h1 = '{1'b1, 1'b1, 1'b0, 1'b0};
    o0 = '{4'h5, 4'h3, 4'h2, 4'h2};
    o1 = '{4'h9, 4'hd, 4'h0, 4'h0};
    reset_card(1'b0);
    @(negedge core_clk);
    check({wait_n, ide_mode, core_held_in_reset}, 3'b100);
    check({ireq_oe, ireq_n_out}, 2'b11);
    host.attr_rd(11'h200, 8'h00, 1'b1);
    host.attr_rd(11'h202, 8'h00, 1'b1);
    host.attr_rd(11'h204, 8'h02, 1'b1);
    host.attr_rd(11'h206, 8'h00, 1'b1);
    host.attr_rd(11'h210, 8'h00, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      opt = {1'b0, i[0], 6'(i)};
      host.attr_wr(11'h200, opt);
      host.attr_rd(11'h200, opt, 1'b1);
      @(negedge core_clk);
      check({4'h0, irq_line}, (i >= 2) ? 8'h0e : 8'h00);
      host.tf_acc(i == 0, i[0], a0[i], 1'b1, o0[i]);
      host.tf_acc(i == 0, 1'b0, a1[i], h1[i], o1[i]);
    end
    host.attr_wr(11'h200, 8'h04);
    host.tf_acc(1'b0, 1'b0, 11'h003, 1'b0, 4'h0);
    host.attr_wr(11'h200, 8'h01);
    host.attr_wr(11'h202, 8'h64);
    @(posedge core_clk);
    irq_request <= 1'b1;
    host.attr_rd(11'h202, 8'h66, 1'b1);
    @(negedge core_clk);
    check({sleep_request, eight_bit_io_only}, 2'b11);
    @(posedge core_clk);
    irq_disable_bit <= 1'b1;
    host.attr_rd(11'h202, 8'h64, 1'b1);
    @(posedge core_clk);
    irq_disable_bit <= 1'b0;
    irq_request <= 1'b0;
    ready_busy_state <= 1'b0;
    host.attr_rd(11'h202, 8'he4, 1'b1);
    host.attr_rd(11'h204, 8'h20, 1'b1);
    @(negedge core_clk);
    check({7'h00, status_change_n}, 8'h00);
    host.attr_wr(11'h202, 8'h24);
    @(negedge core_clk);
    check({7'h00, status_change_n}, 8'h01);
    host.attr_wr(11'h204, 8'h00);
    host.attr_rd(11'h202, 8'h24, 1'b1);
    @(posedge core_clk);
    irq_request <= 1'b1;
    cnt = 0;
    repeat (40)
    begin
      @(negedge core_clk);
      if (ireq_oe === 1'b1 && ireq_n_out === 1'b0)
        cnt++;
    end
    check(8'(cnt), 8'(card_cfg_pkg::PULSE_CYCLES));
    host.attr_wr(11'h200, 8'h41);
    repeat (2) @(negedge core_clk);
    check({ireq_oe, ireq_n_out}, 2'b10);
    @(posedge core_clk);
    irq_request <= 1'b0;
    repeat (3) @(negedge core_clk);
    check({7'h00, ireq_oe}, 8'h00);
    host.attr_wr(11'h200, 8'hc3);
    host.attr_rd(11'h200, 8'h80, 1'b1);
    host.attr_wr(11'h202, 8'h64);
    host.tf_acc(1'b1, 1'b0, 11'h003, 1'b0, 4'h0);
    repeat (10) @(negedge core_clk);
    check({7'h00, core_held_in_reset}, 8'h01);
    host.attr_wr(11'h200, 8'h00);
    @(negedge core_clk);
    check({7'h00, core_held_in_reset}, 8'h00);
    host.attr_rd(11'h202, 8'h00, 1'b1);
    reset_card(1'b1);
    @(negedge core_clk);
    check({7'h00, ide_mode}, 8'h01);
    host.attr_rd(11'h200, 8'h00, 1'b0);
    repeat (4) @(posedge core_clk);
    results();
  end
endmodule

// ==== dv/host_socket_model.sv ====
// host socket controller model driving the card bus
`timescale 1ns/10ps
module host_socket_model (
  // clock
  input wire logic core_clk,
  // card pins
  input wire logic wait_n,
  output card_cfg_pkg::host_bus_t host_bus
);
  logic ide_strap;
  logic [7:0] rd_q[$];
  logic [4:0] tf_q[$];

  initial
  begin
    ide_strap = 1'b0;
    host_bus = {6'h3f, 11'h000, 8'h00};
  end

  // released bus: strobes high except output enable, low while the IDE strap is set; stale lines inverted
  task automatic idle();
    host_bus.reg_n <= 1'b1;
    host_bus.ce1_n <= 1'b1;
    host_bus.oe_n <= ~ide_strap;
    host_bus.we_n <= 1'b1;
    host_bus.iord_n <= 1'b1;
    host_bus.iowr_n <= 1'b1;
    host_bus.addr <= ~host_bus.addr;
    host_bus.wdata <= ~host_bus.wdata;
  endtask

  // hold the cycle while the card asks for wait
  task automatic hold_cycle();
    @(posedge core_clk);
    while (wait_n !== 1'b1) @(posedge core_clk);
    idle();
    @(posedge core_clk);
  endtask

  task automatic attr_wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge core_clk);
    host_bus.reg_n <= 1'b0;
    host_bus.ce1_n <= 1'b0;
    host_bus.we_n <= 1'b0;
    host_bus.addr <= a;
    host_bus.wdata <= d;
    hold_cycle();
  endtask

  task automatic attr_rd(input logic [10:0] a, input logic [7:0] e, input logic resp);
    if (resp)
      rd_q.push_back(e);
    @(posedge core_clk);
    host_bus.reg_n <= 1'b0;
    host_bus.ce1_n <= 1'b0;
    host_bus.oe_n <= 1'b0;
    host_bus.addr <= a;
    hold_cycle();
  endtask

  // task file access, memory or io strobes
  task automatic tf_acc(input logic mem, input logic wr, input logic [10:0] a, input logic hit,
                        input logic [3:0] off);
    if (hit)
      tf_q.push_back({wr, off});
    @(posedge core_clk);
    host_bus.reg_n <= mem;
    host_bus.ce1_n <= 1'b0;
    host_bus.addr <= a;
    host_bus.wdata <= 8'h5a;
    if (mem)
    begin
      host_bus.oe_n <= wr;
      host_bus.we_n <= ~wr;
    end
    else
    begin
      host_bus.iord_n <= wr;
      host_bus.iowr_n <= ~wr;
    end
    hold_cycle();
  endtask
endmodule

// ==== rtl/card_cfg_pkg.sv ====
// shared constants and types for the card configuration registers
package card_cfg_pkg;

  // attribute offsets of the configuration registers
  localparam logic [10:0] OPTION_OFFSET = 11'h200;
  localparam logic [10:0] STATUS_OFFSET = 11'h202;
  localparam logic [10:0] PINREPL_OFFSET = 11'h204;

  // option register fields
  localparam int OPT_CARD_SOFT_RESET_BIT = 7;
  localparam int OPT_LEVEL_BIT = 6;
  localparam int OPT_MODE_MSB = 5;

  // status and pin replacement fields
  localparam int STS_CHANGED_BIT = 7;
  localparam int STS_STATUS_CHANGE_ENABLE_BIT = 6;
  localparam int STS_IO8_BIT = 5;
  localparam int STS_PWD_BIT = 2;
  localparam int STS_IRQ_PENDING_BIT = 1;
  localparam int PIN_RDY_CHG_BIT = 5;
  localparam int PIN_RDY_BIT = 1;
  localparam logic [7:0] REG_RESET = 8'h00;

  // mode select codes
  localparam logic [5:0] MODE_MEMORY = 6'h00;
  localparam logic [5:0] MODE_CONTIG = 6'h01;
  localparam logic [5:0] MODE_PRIMARY = 6'h02;
  localparam logic [5:0] MODE_SECONDARY = 6'h03;

  // task file decode
  localparam int MEM_HIGH_BIT = 10;
  localparam int MEM_WINDOW_BYTES = 2048;
  localparam logic [9:0] PRI_TF_BASE = 10'h1f0;
  localparam logic [9:0] PRI_CTL_BASE = 10'h3f6;
  localparam logic [9:0] SEC_TF_BASE = 10'h170;
  localparam logic [9:0] SEC_CTL_BASE = 10'h376;
  localparam logic [2:0] TF_EVEN_PREFIX = 3'h4;
  localparam logic [2:0] TF_CTL_PREFIX = 3'h7;

  // interrupt
  localparam logic [3:0] IRQ_LINE_DISK = 4'he;
  localparam int PULSE_NS = 500;
  localparam int CLK_PERIOD_NS = 25;
  localparam int PULSE_CYCLES = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W = 5;

  typedef struct packed {
    logic reg_n;
    logic ce1_n;
    logic oe_n;
    logic we_n;
    logic iord_n;
    logic iowr_n;
    logic [10:0] addr;
    logic [7:0] wdata;
  } host_bus_t;

  typedef struct packed {
    logic card_soft_reset;
    logic level_irq_select;
    logic [OPT_MODE_MSB:0] mode;
  } option_t;

  typedef enum logic [1:0] {
    IRQ_IDLE = 2'b00,
    IRQ_PULSE = 2'b01,
    IRQ_DONE = 2'b11
  } irq_state_t;

endpackage

// ==== rtl/card_config_registers.sv ====
// configuration option and status registers of the storage card
//
// What this block does
// - registers unreachable in IDE compatible mode
// - soft reset bit holds card in reset
// - level select: zero pulse, one level
// - resets force mode field to zero
// - mode zero: memory mapped task file
// - mode one: four address lines, 8/16 bit
// - mode two: primary disk addresses
// - mode three: secondary disk addresses
// - registers at 200, 202, 204
// - changed flag mirrors ready change latch
// - io mode: flag and enable drive pin low
// - io mode: enable zero keeps pin high
// - power down bit: one sleeps, zero wakes
// - pending bit shows internal request
// - pending reads zero while interrupts disabled
// - shared request, pulse and level supported
// - disk modes use only line fourteen
// - memory mode maps 2048 bytes at zero
// - only indices zero to three valid
// - card never asks for wait states
// - output enable low at power up: IDE
// - ready state change sets change latch
`timescale 1ns/10ps
module card_config_registers (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // socket pins
  input wire card_cfg_pkg::host_bus_t host_bus,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic status_change_n,
  output logic ireq_n_out,
  output logic ireq_oe,
  output logic wait_n,
  // card core status
  input wire logic ready_busy_state,
  input wire logic irq_request,
  input wire logic irq_disable_bit,
  // card core control
  output logic core_held_in_reset,
  output logic sleep_request,
  output logic eight_bit_io_only,
  output logic ide_mode,
  output logic [3:0] irq_line,
  // task file selects
  output logic taskfile_hit,
  output logic taskfile_write,
  output logic [3:0] taskfile_offset
);

  card_cfg_pkg::option_t option;
  logic strap_done;
  logic we_prev;
  logic ready_prev;
  logic status_changed_flag;
  logic status_change_enable;
  logic power_down_request;
  logic irq_pending;
  logic attr_sel;
  logic attr_wr;
  logic attr_rd;
  logic wr_option;
  logic wr_status;
  logic wr_pinrepl;
  logic rdy_edge;
  logic io_mode;
  logic disk_mode;
  logic [7:0] next_rdata;

  // strap caught once after power-on reset
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      strap_done <= 1'b0;
      ide_mode <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_done <= 1'b1;
      ide_mode <= !host_bus.oe_n;
    end
  end

  // attribute access is off in IDE mode
  assign attr_sel = strap_done && !ide_mode && !host_bus.reg_n && !host_bus.ce1_n;
  assign attr_wr = attr_sel && !host_bus.we_n && we_prev;
  assign attr_rd = attr_sel && !host_bus.oe_n;
  assign wr_option = attr_wr && host_bus.addr == card_cfg_pkg::OPTION_OFFSET;
  assign wr_status = attr_wr && host_bus.addr == card_cfg_pkg::STATUS_OFFSET;
  assign wr_pinrepl = attr_wr && host_bus.addr == card_cfg_pkg::PINREPL_OFFSET;
  // no edge until the history holds a real sample
  assign rdy_edge = strap_done && (ready_busy_state != ready_prev);
  assign io_mode = !ide_mode && option.mode != card_cfg_pkg::MODE_MEMORY
    && option.mode <= card_cfg_pkg::MODE_SECONDARY;
  assign disk_mode = io_mode && option.mode != card_cfg_pkg::MODE_CONTIG;
  assign irq_pending = irq_request && !irq_disable_bit;

  // write strobe edge detect and ready history
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      we_prev <= 1'b1;
      ready_prev <= 1'b0;
    end
    else
    begin
      we_prev <= host_bus.we_n;
      ready_prev <= ready_busy_state;
    end
  end

  // option register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      option <= card_cfg_pkg::REG_RESET;
    else if (wr_option)
    begin
      option.card_soft_reset <= host_bus.wdata[card_cfg_pkg::OPT_CARD_SOFT_RESET_BIT];
      if (host_bus.wdata[card_cfg_pkg::OPT_CARD_SOFT_RESET_BIT])
      begin
        option.level_irq_select <= 1'b0;
        option.mode <= card_cfg_pkg::MODE_MEMORY;
      end
      else
      begin
        option.level_irq_select <= host_bus.wdata[card_cfg_pkg::OPT_LEVEL_BIT];
        option.mode <= host_bus.wdata[card_cfg_pkg::OPT_MODE_MSB:0];
      end
    end
  end

  // host fields of the status register, cleared by soft reset
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      status_change_enable <= 1'b0;
      eight_bit_io_only <= 1'b0;
      power_down_request <= 1'b0;
    end
    else if (option.card_soft_reset)
    begin
      status_change_enable <= 1'b0;
      eight_bit_io_only <= 1'b0;
      power_down_request <= 1'b0;
    end
    else if (wr_status)
    begin
      status_change_enable <= host_bus.wdata[card_cfg_pkg::STS_STATUS_CHANGE_ENABLE_BIT];
      eight_bit_io_only <= host_bus.wdata[card_cfg_pkg::STS_IO8_BIT];
      power_down_request <= host_bus.wdata[card_cfg_pkg::STS_PWD_BIT];
    end
  end

  // ready change latch, set wins over clear
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      status_changed_flag <= 1'b0;
    else if (rdy_edge)
      status_changed_flag <= 1'b1;
    else if (option.card_soft_reset)
      status_changed_flag <= 1'b0;
    else if (wr_pinrepl)
      status_changed_flag <= host_bus.wdata[card_cfg_pkg::PIN_RDY_CHG_BIT];
  end

  // read data
  always_comb
  begin
    next_rdata = 8'h00;
    if (host_bus.addr == card_cfg_pkg::OPTION_OFFSET)
      next_rdata = option;
    else if (host_bus.addr == card_cfg_pkg::STATUS_OFFSET)
    begin
      next_rdata[card_cfg_pkg::STS_CHANGED_BIT] = status_changed_flag;
      next_rdata[card_cfg_pkg::STS_STATUS_CHANGE_ENABLE_BIT] = status_change_enable;
      next_rdata[card_cfg_pkg::STS_IO8_BIT] = eight_bit_io_only;
      next_rdata[card_cfg_pkg::STS_PWD_BIT] = power_down_request;
      next_rdata[card_cfg_pkg::STS_IRQ_PENDING_BIT] = irq_pending;
    end
    else if (host_bus.addr == card_cfg_pkg::PINREPL_OFFSET)
    begin
      next_rdata[card_cfg_pkg::PIN_RDY_CHG_BIT] = status_changed_flag;
      next_rdata[card_cfg_pkg::PIN_RDY_BIT] = ready_busy_state;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end
    else
    begin
      data_out <= attr_rd ? next_rdata : 8'h00;
      data_oe <= attr_rd;
    end
  end

  // pins and core controls
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      status_change_n <= 1'b1;
      wait_n <= 1'b1;
      core_held_in_reset <= 1'b1;
      sleep_request <= 1'b0;
      irq_line <= 4'h0;
    end
    else
    begin
      status_change_n <= !(io_mode && status_changed_flag && status_change_enable);
      wait_n <= 1'b1;
      core_held_in_reset <= option.card_soft_reset;
      sleep_request <= power_down_request;
      irq_line <= disk_mode ? card_cfg_pkg::IRQ_LINE_DISK : 4'h0;
    end
  end

  taskfile_decode u_decode (
    .core_clk(core_clk),
    .rst(rst),
    .enable(strap_done && !ide_mode && !option.card_soft_reset),
    .mode(option.mode),
    .host_bus(host_bus),
    .taskfile_hit(taskfile_hit),
    .taskfile_write(taskfile_write),
    .taskfile_offset(taskfile_offset)
  );

  irq_shaper u_irq (
    .core_clk(core_clk),
    .rst(rst),
    .io_mode(io_mode),
    .level_irq_select(option.level_irq_select),
    .irq_pending(irq_pending),
    .ready_busy_state(ready_busy_state),
    .ireq_n_out(ireq_n_out),
    .ireq_oe(ireq_oe)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_ide_silent;
    ide_mode |=> !data_oe;
  endproperty
  a_ide_silent: assert property (p_ide_silent) else $error("register read in IDE mode");

  sequence s_card_soft_reset_write;
    wr_option && host_bus.wdata[card_cfg_pkg::OPT_CARD_SOFT_RESET_BIT];
  endsequence
  property p_card_soft_reset_holds;
    s_card_soft_reset_write |=> option.card_soft_reset ##1 core_held_in_reset;
  endproperty
  a_card_soft_reset_holds: assert property (p_card_soft_reset_holds) else $error("soft reset not applied");

  property p_card_soft_reset_mode;
    option.card_soft_reset |-> option.mode == card_cfg_pkg::MODE_MEMORY && !option.level_irq_select;
  endproperty
  a_card_soft_reset_mode: assert property (p_card_soft_reset_mode) else $error("mode not zero in reset");

  property p_card_soft_reset_sticky;
    option.card_soft_reset && !wr_option |=> option.card_soft_reset;
  endproperty
  a_card_soft_reset_sticky: assert property (p_card_soft_reset_sticky) else $error("soft reset cleared itself");

  property p_pin_low;
    io_mode && status_changed_flag && status_change_enable |=> !status_change_n;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("status change pin not low");

  property p_pin_high;
    !status_change_enable |=> status_change_n;
  endproperty
  a_pin_high: assert property (p_pin_high) else $error("status change pin not high");

  property p_ready_latch;
    rdy_edge |=> status_changed_flag;
  endproperty
  a_ready_latch: assert property (p_ready_latch) else $error("ready change not latched");

  property p_irq_pending_masked;
    attr_rd && host_bus.addr == card_cfg_pkg::STATUS_OFFSET && irq_disable_bit
      |=> !data_out[card_cfg_pkg::STS_IRQ_PENDING_BIT];
  endproperty
  a_irq_pending_masked: assert property (p_irq_pending_masked) else $error("pending bit shown while disabled");

  sequence s_pwd_write;
    wr_status && !option.card_soft_reset;
  endsequence
  property p_power_down;
    s_pwd_write |=> ##1 sleep_request == $past(host_bus.wdata[card_cfg_pkg::STS_PWD_BIT], 2);
  endproperty
  a_power_down: assert property (p_power_down) else $error("sleep request wrong");

endmodule

// ==== rtl/irq_shaper.sv ====
// interrupt pin shaping: pulse or level, shared drive
`timescale 1ns/10ps
module irq_shaper (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic io_mode,
  input wire logic level_irq_select,
  input wire logic irq_pending,
  input wire logic ready_busy_state,
  // pin
  output logic ireq_n_out,
  output logic ireq_oe
);

  card_cfg_pkg::irq_state_t state;
  logic [card_cfg_pkg::PULSE_CNT_W-1:0] cnt;
  logic assert_now;
  logic [card_cfg_pkg::PULSE_CNT_W:0] oe_run;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= card_cfg_pkg::IRQ_IDLE;
      cnt <= '0;
    end
    else
    begin
      case (state)
        card_cfg_pkg::IRQ_IDLE:
          if (irq_pending && io_mode && !level_irq_select)
          begin
            state <= card_cfg_pkg::IRQ_PULSE;
            cnt <= card_cfg_pkg::PULSE_CNT_W'(card_cfg_pkg::PULSE_CYCLES - 1);
          end
        card_cfg_pkg::IRQ_PULSE:
          if (cnt == '0)
            state <= card_cfg_pkg::IRQ_DONE;
          else
            cnt <= cnt - 1'b1;
        card_cfg_pkg::IRQ_DONE:
          if (!irq_pending)
            state <= card_cfg_pkg::IRQ_IDLE;
        default:
          state <= card_cfg_pkg::IRQ_IDLE;
      endcase
    end
  end

  // level follows pending, pulse follows the timer
  assign assert_now = level_irq_select ? irq_pending : (state == card_cfg_pkg::IRQ_PULSE);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ireq_n_out <= 1'b1;
      ireq_oe <= 1'b0;
    end
    else if (io_mode)
    begin
      // drive only while asserting, so the line can be shared
      ireq_n_out <= 1'b0;
      ireq_oe <= assert_now;
    end
    else
    begin
      ireq_n_out <= ready_busy_state;
      ireq_oe <= 1'b1;
    end
  end

  // length of the current driven pulse, for the width check
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      oe_run <= '0;
    else if (io_mode && !level_irq_select && ireq_oe)
      oe_run <= oe_run + 1'b1;
    else
      oe_run <= '0;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_level;
    io_mode && level_irq_select && irq_pending |=> ireq_oe && !ireq_n_out;
  endproperty
  a_level: assert property (p_level) else $error("level request not driven");

  sequence s_pulse_start;
    state == card_cfg_pkg::IRQ_IDLE && irq_pending && io_mode && !level_irq_select;
  endsequence
  sequence s_pulse_held;
    io_mode && !level_irq_select;
  endsequence
  property p_pulse_starts;
    s_pulse_start ##1 s_pulse_held |=> ireq_oe && !ireq_n_out;
  endproperty
  a_pulse_starts: assert property (p_pulse_starts) else $error("pulse not driven");

  property p_pulse_ends;
    oe_run == card_cfg_pkg::PULSE_CYCLES |-> !ireq_oe;
  endproperty
  a_pulse_ends: assert property (p_pulse_ends) else $error("pulse width wrong");

endmodule

// ==== rtl/taskfile_decode.sv ====
// task file address decode for the four mapping modes
`timescale 1ns/10ps
module taskfile_decode (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // configuration
  input wire logic enable,
  input wire logic [5:0] mode,
  input wire card_cfg_pkg::host_bus_t host_bus,
  // decode result
  output logic taskfile_hit,
  output logic taskfile_write,
  output logic [3:0] taskfile_offset
);

  logic mem_cyc;
  logic io_cyc;
  logic next_hit;
  logic [3:0] next_off;

  // disk style decode: returns {hit, offset}
  function automatic logic [4:0] disk_decode(input logic [10:0] a, input logic [9:0] tf, input logic [9:0] ctl);
    logic [4:0] r;
    r = 5'h00;
    if ({a[9:3], 3'h0} == tf)
      r = {1'b1, 1'b0, a[2:0]};
    else if ({a[9:1], 1'b0} == ctl)
      r = {1'b1, card_cfg_pkg::TF_CTL_PREFIX, a[0]};
    return r;
  endfunction

  assign mem_cyc = host_bus.reg_n && !host_bus.ce1_n && (!host_bus.oe_n || !host_bus.we_n);
  assign io_cyc = !host_bus.reg_n && !host_bus.ce1_n && (!host_bus.iord_n || !host_bus.iowr_n);

  always_comb
  begin
    next_hit = 1'b0;
    next_off = 4'h0;
    if (enable)
    begin
      case (mode)
        card_cfg_pkg::MODE_MEMORY:
        begin
          // whole 11-bit window from card address zero
          if (mem_cyc)
          begin
            next_hit = 1'b1;
            next_off = host_bus.addr[card_cfg_pkg::MEM_HIGH_BIT] ?
              {card_cfg_pkg::TF_EVEN_PREFIX, host_bus.addr[0]} : host_bus.addr[3:0];
          end
        end
        card_cfg_pkg::MODE_CONTIG:
        begin
          next_hit = io_cyc;
          next_off = host_bus.addr[3:0];
        end
        card_cfg_pkg::MODE_PRIMARY:
          {next_hit, next_off} = io_cyc ? disk_decode(host_bus.addr, card_cfg_pkg::PRI_TF_BASE,
            card_cfg_pkg::PRI_CTL_BASE) : 5'h00;
        card_cfg_pkg::MODE_SECONDARY:
          {next_hit, next_off} = io_cyc ? disk_decode(host_bus.addr, card_cfg_pkg::SEC_TF_BASE,
            card_cfg_pkg::SEC_CTL_BASE) : 5'h00;
        default:
          next_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      taskfile_hit <= 1'b0;
      taskfile_write <= 1'b0;
      taskfile_offset <= 4'h0;
    end
    else
    begin
      taskfile_hit <= next_hit;
      taskfile_write <= next_hit && (!host_bus.we_n || !host_bus.iowr_n);
      taskfile_offset <= next_off;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_primary_base;
    enable && mode == card_cfg_pkg::MODE_PRIMARY && io_cyc
      && host_bus.addr[9:3] == card_cfg_pkg::PRI_TF_BASE[9:3]
      |=> taskfile_hit && taskfile_offset == {1'b0, $past(host_bus.addr[2:0])};
  endproperty
  a_primary_base: assert property (p_primary_base) else $error("primary base not decoded");

  property p_bad_index;
    mode > card_cfg_pkg::MODE_SECONDARY |=> !taskfile_hit;
  endproperty
  a_bad_index: assert property (p_bad_index) else $error("invalid index decoded");

endmodule
